/* pkg/csq_pkg.sv */
// Package: constants, commands and state types of the CPU register sequencer
//
// Overview of operation
// - Indexed address is X, X plus 8-bit offset, or X plus 16-bit offset
// - Index register keeps its contents through any reset
// - Reset and reset-stack instruction load the stack pointer with $00FF
// - Pointer names next free byte; decrement after push, increment before pull
// - Stack address is $00C0 plus six pointer bits; overflow wraps silently
// - Subroutine call pushes two bytes, interrupt entry pushes five
// - Program counter steps by one per fetch; jumps and entries load targets
// - Five flag bits, upper three read one, reset touches only the mask
// - Half carry is the carry from bit 3 into bit 4 on add
// - Mask blocks maskable interrupts while requests stay latched
// - Mask is set after stacking and before the vector fetch
// - Return from interrupt pulls all registers and restores the mask
// - Reset sets the mask; clear-mask, stop or wait clear it, return from interrupt restores it
// - Negative is result bit 7; zero set for zero result or load
// - Carry from bit 7, bit test and shifts; increment/decrement leave it
// - Requests wait for instruction end; reset acts at once
// - Entry only with mask clear and source enabled, else carry on
// - After stacking, the pending source with highest vector wins
// - Vector table from $3FFF down: reset, software, ext, t16, net, spi, t8
// - Software interrupt ignores the mask and runs after earlier requests
// - Reset loads the program counter from $3FFE/$3FFF and sets the mask
// - Latency bounded by longest instruction plus ten cycles of overhead
// - Accumulator keeps its contents through any reset
package csq_pkg;

   // Stack layout
   localparam logic [5:0] CSQ_SP_RST = 6'h3F;
   localparam logic [15:0] CSQ_STK_BASE = 16'h00C0;
   localparam logic [2:0] CSQ_INT_LAST = 3'h4;
   localparam logic [2:0] CSQ_JSR_LAST = 3'h1;
   localparam logic [2:0] CSQ_RTS_FIRST = 3'h3;
   localparam int CSQ_STACK_OVERHEAD_CYC = 10;

   // Vector table bases, high byte first
   localparam logic [15:0] CSQ_VEC_RST = 16'h3FFE;
   localparam logic [15:0] CSQ_VEC_SWI = 16'h3FFC;
   localparam logic [15:0] CSQ_VEC_EXT = 16'h3FFA;
   localparam logic [15:0] CSQ_VEC_T16 = 16'h3FF8;
   localparam logic [15:0] CSQ_VEC_NET = 16'h3FF6;
   localparam logic [15:0] CSQ_VEC_SPI = 16'h3FF4;
   localparam logic [15:0] CSQ_VEC_T8 = 16'h3FF2;

   // Vector select codes
   localparam logic [2:0] CSQ_SEL_RST = 3'h0;
   localparam logic [2:0] CSQ_SEL_SWI = 3'h1;
   localparam logic [2:0] CSQ_SEL_EXT = 3'h2;

   // Hardware sources: bit 0 external, then t16, net, spi, t8
   localparam int CSQ_NSRC = 5;
   localparam logic [4:0] CSQ_EN_RST = 5'h01;

   // Register port map
   localparam logic [1:0] CSQ_REG_EN = 2'h0;
   localparam logic [1:0] CSQ_REG_ACK = 2'h1;
   localparam logic [1:0] CSQ_REG_FLAGS = 2'h2;
   localparam logic [1:0] CSQ_REG_PEND = 2'h3;
   localparam logic [2:0] CSQ_FLAG_ONES = 3'h7;

   typedef enum logic [4:0] {
      CSQ_OP_NOP, CSQ_OP_FETCH, CSQ_OP_JUMP, CSQ_OP_LDA, CSQ_OP_LDX,
      CSQ_OP_ADD, CSQ_OP_ADC, CSQ_OP_SUB, CSQ_OP_AND, CSQ_OP_INC,
      CSQ_OP_DEC, CSQ_OP_LSL, CSQ_OP_BTST, CSQ_OP_IDX0, CSQ_OP_IDX8,
      CSQ_OP_IDX16, CSQ_OP_RSP, CSQ_OP_CLI, CSQ_OP_SEI, CSQ_OP_STPWT,
      CSQ_OP_JSR, CSQ_OP_RTS, CSQ_OP_RTI, CSQ_OP_SWI, CSQ_OP_END
   } csq_op_e;

   typedef enum logic [2:0] {
      CSQ_ST_RST, CSQ_ST_RUN, CSQ_ST_PUSH, CSQ_ST_PULL_RD,
      CSQ_ST_PULL_CAP, CSQ_ST_VEC_RD, CSQ_ST_VEC_HI, CSQ_ST_VEC_LO
   } csq_state_e;

   typedef enum logic [1:0] {
      CSQ_KIND_INT, CSQ_KIND_SWI, CSQ_KIND_JSR, CSQ_KIND_RET
   } csq_kind_e;

   typedef struct packed {
      csq_op_e op;
      logic [15:0] opd;
   } csq_cmd_s;

   typedef struct packed {
      csq_state_e st;
      csq_kind_e kind;
      logic [7:0] a;
      logic [7:0] x;
      logic [5:0] sp;
      logic [15:0] pc;
      logic h, i, n, z, c;
      logic [2:0] cnt;
      logic [2:0] vsel;
      logic [7:0] vhi;
      logic [15:0] tgt;
      logic [15:0] ea;
      logic [15:0] mem_addr;
      logic [7:0] mem_wdata;
      logic mem_we;
      logic mem_re;
      logic [7:0] rd_data;
      logic [4:0] en;
      logic busy;
      logic vec_clr;
      logic ack;
   } csq_core_s;

   typedef struct packed {
      logic sync1;
      logic sync2;
      logic prev;
      logic ext;
   } csq_irq_s;

endpackage : csq_pkg

/* verilog/csq_irq.sv */
// External request latch, source gating and vector priority select
`timescale 1ns/1ps
`default_nettype none
module csq_irq
   import csq_pkg::*;
#(
   parameter int NSRC = CSQ_NSRC
) (
   input wire logic i_ref_clk,
   input wire logic i_srst,
   input wire logic i_irq_pin_n,
   input wire logic [3:0] i_periph_req,
   input wire logic [4:0] i_enable,
   input wire logic i_ack,
   input wire logic i_vec_clr,
   output logic [4:0] o_pend,
   output logic o_any,
   output logic [2:0] o_sel
);

   // Source order is tied to the vector table
   if (NSRC != 5) begin : g_chk
      $error("csq_irq: NSRC must be 5");
   end

   csq_irq_s r, r_nxt;
   logic fall;

   // Pin synchroniser, edge detect and latch; set beats clear
   always_comb begin
      r_nxt = r;
      r_nxt.sync1 = i_irq_pin_n;
      r_nxt.sync2 = r.sync1;
      r_nxt.prev = r.sync2;
      fall = r.prev & ~r.sync2;
      if (i_ack || i_vec_clr) begin
         r_nxt.ext = 1'b0;
      end
      if (fall && i_enable[0]) begin
         r_nxt.ext = 1'b1;
      end
      if (i_srst) begin
         r_nxt = '{sync1: 1'b1, sync2: 1'b1, prev: 1'b1, ext: 1'b0};
      end
   end

   always_ff @(posedge i_ref_clk) begin
      r <= r_nxt;
   end

   // Lowest set bit has the highest vector
   always_comb begin
      o_pend = {i_periph_req, r.ext} & i_enable;
      o_any = |o_pend;
      o_sel = CSQ_SEL_EXT;
      for (int k = NSRC - 1; k >= 0; k--) begin
         if (o_pend[k]) begin
            o_sel = CSQ_SEL_EXT + 3'(k);
         end
      end
   end

endmodule : csq_irq
`default_nettype wire

/* verilog/csq_core.sv */
// CPU register file, flag logic and interrupt/stack sequencer
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module csq_core
   import csq_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_srst,
   input wire logic i_cmd_valid,
   input wire csq_cmd_s i_cmd,
   output logic o_busy,
   output logic [15:0] o_ea,
   output logic [15:0] o_pc,
   output logic [15:0] o_mem_addr,
   output logic [7:0] o_mem_wdata,
   output logic o_mem_we,
   output logic o_mem_re,
   input wire logic [7:0] i_mem_rdata,
   input wire logic i_irq_pin_n,
   input wire logic [3:0] i_periph_req,
   input wire logic [1:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [7:0] o_reg_rdata
);

   csq_core_s r, r_nxt;
   logic [4:0] pend;
   logic any;
   logic [2:0] sel;
   logic [8:0] s9;
   logic [4:0] s5;
   logic [7:0] res;
   logic upd_a;
   logic cin;

   // Flags byte as software sees it
   function automatic logic [7:0] flags_byte(input csq_core_s s);
      flags_byte = {CSQ_FLAG_ONES, s.h, s.i, s.n, s.z, s.c};
   endfunction : flags_byte

   // Vector pair base for a select code
   function automatic logic [15:0] vec_base(input logic [2:0] v);
      case (v)
         3'h0: vec_base = CSQ_VEC_RST;
         3'h1: vec_base = CSQ_VEC_SWI;
         3'h2: vec_base = CSQ_VEC_EXT;
         3'h3: vec_base = CSQ_VEC_T16;
         3'h4: vec_base = CSQ_VEC_NET;
         3'h5: vec_base = CSQ_VEC_SPI;
         default: vec_base = CSQ_VEC_T8;
      endcase
   endfunction : vec_base

   // Byte pushed at each step of an entry frame
   function automatic logic [7:0] push_byte(input csq_core_s s);
      case (s.cnt)
         3'h0: push_byte = s.pc[7:0];
         3'h1: push_byte = s.pc[15:8];
         3'h2: push_byte = s.x;
         3'h3: push_byte = s.a;
         default: push_byte = flags_byte(s);
      endcase
   endfunction : push_byte

   // Stack byte address from the six pointer bits
   function automatic logic [15:0] stk_addr(input logic [5:0] p);
      stk_addr = CSQ_STK_BASE | {10'h000, p};
   endfunction : stk_addr

   csq_irq u_irq (
      .i_ref_clk(i_ref_clk),
      .i_srst(i_srst),
      .i_irq_pin_n(i_irq_pin_n),
      .i_periph_req(i_periph_req),
      .i_enable(r.en),
      .i_ack(r.ack),
      .i_vec_clr(r.vec_clr),
      .o_pend(pend),
      .o_any(any),
      .o_sel(sel)
   );

   // Next state of the whole core
   always_comb begin
      r_nxt = r;
      r_nxt.mem_we = 1'b0;
      r_nxt.mem_re = 1'b0;
      r_nxt.vec_clr = 1'b0;
      r_nxt.ack = 1'b0;
      r_nxt.rd_data = 8'h00;
      s9 = 9'h000;
      s5 = 5'h00;
      res = r.a;
      upd_a = 1'b0;
      cin = 1'b0;

      // Register port writes and reads
      if (i_reg_wr) begin
         case (i_reg_addr)
            CSQ_REG_EN: r_nxt.en = i_reg_wdata[4:0];
            CSQ_REG_ACK: r_nxt.ack = i_reg_wdata[0];
            default: ;
         endcase
      end
      if (i_reg_rd) begin
         case (i_reg_addr)
            CSQ_REG_EN: r_nxt.rd_data = {3'h0, r.en};
            CSQ_REG_FLAGS: r_nxt.rd_data = flags_byte(r);
            CSQ_REG_PEND: r_nxt.rd_data = {r.busy, 2'h0, pend};
            default: r_nxt.rd_data = 8'h00;
         endcase
      end

      case (r.st)
         // Reset vector fetch after release
         CSQ_ST_RST: begin
            r_nxt.vsel = CSQ_SEL_RST;
            r_nxt.st = CSQ_ST_VEC_RD;
         end

         CSQ_ST_RUN: begin
            if (i_cmd_valid) begin
               case (i_cmd.op)
                  CSQ_OP_NOP: ;
                  CSQ_OP_FETCH: begin
                     r_nxt.mem_re = 1'b1;
                     r_nxt.mem_addr = r.pc;
                     r_nxt.pc = r.pc + 16'h0001;
                  end
                  CSQ_OP_JUMP: r_nxt.pc = i_cmd.opd;
                  CSQ_OP_LDA: begin
                     res = i_cmd.opd[7:0];
                     upd_a = 1'b1;
                  end
                  CSQ_OP_LDX: begin
                     r_nxt.x = i_cmd.opd[7:0];
                     r_nxt.n = i_cmd.opd[7];
                     r_nxt.z = (i_cmd.opd[7:0] == 8'h00);
                  end
                  CSQ_OP_ADD, CSQ_OP_ADC: begin
                     cin = (i_cmd.op == CSQ_OP_ADC) & r.c;
                     s5 = {1'b0, r.a[3:0]} + {1'b0, i_cmd.opd[3:0]}
                        + {4'h0, cin};
                     s9 = {1'b0, r.a} + {1'b0, i_cmd.opd[7:0]}
                        + {8'h00, cin};
                     r_nxt.h = s5[4];
                     r_nxt.c = s9[8];
                     res = s9[7:0];
                     upd_a = 1'b1;
                  end
                  CSQ_OP_SUB: begin
                     s9 = {1'b0, r.a} - {1'b0, i_cmd.opd[7:0]};
                     r_nxt.c = s9[8];
                     res = s9[7:0];
                     upd_a = 1'b1;
                  end
                  CSQ_OP_AND: begin
                     res = r.a & i_cmd.opd[7:0];
                     upd_a = 1'b1;
                  end
                  // Carry deliberately left alone here
                  CSQ_OP_INC: begin
                     res = r.a + 8'h01;
                     upd_a = 1'b1;
                  end
                  CSQ_OP_DEC: begin
                     res = r.a - 8'h01;
                     upd_a = 1'b1;
                  end
                  CSQ_OP_LSL: begin
                     r_nxt.c = r.a[7];
                     res = {r.a[6:0], 1'b0};
                     upd_a = 1'b1;
                  end
                  CSQ_OP_BTST: r_nxt.c = i_cmd.opd[0];
                  CSQ_OP_IDX0: r_nxt.ea = {8'h00, r.x};
                  CSQ_OP_IDX8: begin
                     r_nxt.ea = {8'h00, r.x} + {8'h00, i_cmd.opd[7:0]};
                  end
                  CSQ_OP_IDX16: r_nxt.ea = {8'h00, r.x} + i_cmd.opd;
                  CSQ_OP_RSP: r_nxt.sp = CSQ_SP_RST;
                  // Only these two commands clear the mask outright; RTI can restore it clear from the stack
                  CSQ_OP_CLI, CSQ_OP_STPWT: r_nxt.i = 1'b0;
                  CSQ_OP_SEI: r_nxt.i = 1'b1;
                  CSQ_OP_JSR: begin
                     r_nxt.tgt = i_cmd.opd;
                     r_nxt.kind = CSQ_KIND_JSR;
                     r_nxt.cnt = 3'h0;
                     r_nxt.st = CSQ_ST_PUSH;
                  end
                  CSQ_OP_RTS: begin
                     r_nxt.kind = CSQ_KIND_RET;
                     r_nxt.cnt = CSQ_RTS_FIRST;
                     r_nxt.st = CSQ_ST_PULL_RD;
                  end
                  CSQ_OP_RTI: begin
                     r_nxt.kind = CSQ_KIND_RET;
                     r_nxt.cnt = 3'h0;
                     r_nxt.st = CSQ_ST_PULL_RD;
                  end
                  // Taken whatever the mask; earlier requests went first
                  CSQ_OP_SWI: begin
                     r_nxt.kind = CSQ_KIND_SWI;
                     r_nxt.cnt = 3'h0;
                     r_nxt.st = CSQ_ST_PUSH;
                  end
                  // Instruction boundary: only place a request is taken
                  CSQ_OP_END: begin
                     if (!r.i && any) begin
                        r_nxt.kind = CSQ_KIND_INT;
                        r_nxt.cnt = 3'h0;
                        r_nxt.st = CSQ_ST_PUSH;
                     end
                  end
                  default: ;
               endcase
            end
         end

         // One byte per cycle, pointer moves after the write
         CSQ_ST_PUSH: begin
            r_nxt.mem_we = 1'b1;
            r_nxt.mem_addr = stk_addr(r.sp);
            r_nxt.mem_wdata = push_byte(r);
            r_nxt.sp = r.sp - 6'h01;
            r_nxt.cnt = r.cnt + 3'h1;
            if (r.kind == CSQ_KIND_JSR && r.cnt == CSQ_JSR_LAST) begin
               r_nxt.pc = r.tgt;
               r_nxt.st = CSQ_ST_RUN;
            end else if (r.cnt == CSQ_INT_LAST) begin
               r_nxt.i = 1'b1;
               // Priority chosen only once the frame is out
               r_nxt.vsel = (r.kind == CSQ_KIND_SWI) ? CSQ_SEL_SWI : sel;
               r_nxt.st = CSQ_ST_VEC_RD;
            end
         end

         // Pointer moves before the read
         CSQ_ST_PULL_RD: begin
            r_nxt.sp = r.sp + 6'h01;
            r_nxt.mem_re = 1'b1;
            r_nxt.mem_addr = stk_addr(r.sp + 6'h01);
            r_nxt.st = CSQ_ST_PULL_CAP;
         end

         // Read data arrive one cycle after the strobe
         CSQ_ST_PULL_CAP: begin
            case (r.cnt)
               3'h0: begin
                  r_nxt.h = i_mem_rdata[4];
                  r_nxt.i = i_mem_rdata[3];
                  r_nxt.n = i_mem_rdata[2];
                  r_nxt.z = i_mem_rdata[1];
                  r_nxt.c = i_mem_rdata[0];
               end
               3'h1: r_nxt.a = i_mem_rdata;
               3'h2: r_nxt.x = i_mem_rdata;
               3'h3: r_nxt.pc[15:8] = i_mem_rdata;
               default: r_nxt.pc[7:0] = i_mem_rdata;
            endcase
            if (r.cnt == CSQ_INT_LAST) begin
               r_nxt.st = CSQ_ST_RUN;
            end else begin
               r_nxt.cnt = r.cnt + 3'h1;
               r_nxt.st = CSQ_ST_PULL_RD;
            end
         end

         // External latch clears itself on its own vector fetch
         CSQ_ST_VEC_RD: begin
            r_nxt.mem_re = 1'b1;
            r_nxt.mem_addr = vec_base(r.vsel);
            r_nxt.vec_clr = (r.vsel == CSQ_SEL_EXT);
            r_nxt.st = CSQ_ST_VEC_HI;
         end

         CSQ_ST_VEC_HI: begin
            r_nxt.vhi = i_mem_rdata;
            r_nxt.mem_re = 1'b1;
            r_nxt.mem_addr = vec_base(r.vsel) + 16'h0001;
            r_nxt.st = CSQ_ST_VEC_LO;
         end

         // Eight cycles from boundary to vector, inside the ten allowed
         CSQ_ST_VEC_LO: begin
            r_nxt.pc = {r.vhi, i_mem_rdata};
            r_nxt.st = CSQ_ST_RUN;
         end

         default: r_nxt.st = CSQ_ST_RUN;
      endcase

      // Common result path for accumulator work
      if (upd_a) begin
         r_nxt.a = res;
         r_nxt.n = res[7];
         r_nxt.z = (res == 8'h00);
      end

      r_nxt.busy = (r_nxt.st != CSQ_ST_RUN);

      // A, X and the result flags are left as they were on purpose
      if (i_srst) begin
         r_nxt.st = CSQ_ST_RST;
         r_nxt.kind = CSQ_KIND_INT;
         r_nxt.sp = CSQ_SP_RST;
         r_nxt.i = 1'b1;
         r_nxt.pc = 16'h0000;
         r_nxt.cnt = 3'h0;
         r_nxt.vsel = CSQ_SEL_RST;
         r_nxt.vhi = 8'h00;
         r_nxt.tgt = 16'h0000;
         r_nxt.ea = 16'h0000;
         r_nxt.mem_addr = 16'h0000;
         r_nxt.mem_wdata = 8'h00;
         r_nxt.mem_we = 1'b0;
         r_nxt.mem_re = 1'b0;
         r_nxt.rd_data = 8'h00;
         r_nxt.en = CSQ_EN_RST;
         r_nxt.busy = 1'b1;
         r_nxt.vec_clr = 1'b0;
         r_nxt.ack = 1'b0;
         r_nxt.a = r.a;
         r_nxt.x = r.x;
         r_nxt.h = r.h;
         r_nxt.n = r.n;
         r_nxt.z = r.z;
         r_nxt.c = r.c;
      end
   end

   // Single state register
   always_ff @(posedge i_ref_clk) begin
      r <= r_nxt;
   end

   // Outputs straight from flops
   assign o_busy = r.busy;
   assign o_ea = r.ea;
   assign o_pc = r.pc;
   assign o_mem_addr = r.mem_addr;
   assign o_mem_wdata = r.mem_wdata;
   assign o_mem_we = r.mem_we;
   assign o_mem_re = r.mem_re;
   assign o_reg_rdata = r.rd_data;

endmodule : csq_core
`default_nettype wire

/* sim/csq_core_sva.sv */
// Port checker for the CPU register and interrupt sequencer
`timescale 1ns/1ps
`default_nettype none
module csq_core_sva
   import csq_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_srst,
   input wire logic i_cmd_valid,
   input wire csq_cmd_s i_cmd,
   input wire logic o_busy,
   input wire logic [15:0] o_ea,
   input wire logic [15:0] o_pc,
   input wire logic [15:0] o_mem_addr,
   input wire logic o_mem_we,
   input wire logic o_mem_re,
   input wire logic [1:0] i_reg_addr,
   input wire logic i_reg_rd,
   input wire logic [7:0] o_reg_rdata
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_srst);
   logic tk;
   // Command accepted on this edge
   assign tk = i_cmd_valid && !o_busy;

   chk_reset_vector: assert property ($fell(i_srst) |-> ##[1:3]
      (o_mem_re && o_mem_addr == CSQ_VEC_RST) ##1 (o_mem_re &&
      o_mem_addr == CSQ_VEC_RST + 16'h1) ##[1:2] !o_busy)
      else $error("reset vector fetch wrong");
   chk_call_pushes: assert property (tk && i_cmd.op == CSQ_OP_JSR |->
      ##2 o_mem_we ##1 o_mem_we ##1 !o_mem_we)
      else $error("call push count wrong");
   chk_call_target: assert property (tk && i_cmd.op == CSQ_OP_JSR |->
      ##3 o_pc == $past(i_cmd.opd, 3))
      else $error("call target not loaded");
   chk_stack_window: assert property (o_mem_we |->
      o_mem_addr[15:6] == 10'h003)
      else $error("push outside stack page");
   chk_push_down: assert property (o_mem_we ##1 o_mem_we |->
      o_mem_addr[5:0] == $past(o_mem_addr[5:0]) - 6'h01)
      else $error("push address not stepping down");
   chk_entry_five: assert property ($rose(o_mem_we) ##1 o_mem_we [*2]
      |-> ##1 o_mem_we ##1 o_mem_we ##1
      (o_mem_re && o_mem_addr[15:4] == 12'h3FF))
      else $error("entry not five pushes then vector");
   chk_swi_vector: assert property (tk && i_cmd.op == CSQ_OP_SWI |->
      ##7 (o_mem_re && o_mem_addr == CSQ_VEC_SWI))
      else $error("software vector not fetched");
   chk_idx_zero: assert property (tk && i_cmd.op == CSQ_OP_IDX0 |=>
      o_ea[15:8] == 8'h00)
      else $error("index high byte not zero");
   chk_flags_ones: assert property ($past(i_reg_rd) &&
      $past(i_reg_addr) == CSQ_REG_FLAGS |-> o_reg_rdata[7:5] == 3'h7)
      else $error("flag upper bits not ones");
   chk_fetch_step: assert property (tk && i_cmd.op == CSQ_OP_FETCH |=>
      o_mem_re && o_mem_addr == $past(o_pc) && o_pc == $past(o_pc) + 16'h1)
      else $error("fetch step wrong");

   // Main scenarios reached
   cov_call: cover property (tk && i_cmd.op == CSQ_OP_JSR);
   cov_swi: cover property (tk && i_cmd.op == CSQ_OP_SWI);
   cov_entry: cover property ($rose(o_mem_we) ##1 o_mem_we [*4]);
endmodule : csq_core_sva
bind csq_core csq_core_sva u_sva (.i_ref_clk, .i_srst, .i_cmd_valid,
   .i_cmd, .o_busy, .o_ea, .o_pc, .o_mem_addr, .o_mem_we, .o_mem_re,
   .i_reg_addr, .i_reg_rd, .o_reg_rdata);
`default_nettype wire

/* sim/csq_mem_model.sv */
// Memory partner: byte array read while the strobe stands
`timescale 1ns/1ps
`default_nettype none
module csq_mem_model (
   input wire logic i_ref_clk,
   input wire logic [15:0] i_mem_addr,
   input wire logic [7:0] i_mem_wdata,
   input wire logic i_mem_we,
   input wire logic i_mem_re,
   output logic [7:0] o_mem_rdata
);
   logic [7:0] mem [0:65535];
   // Vector bytes are A0 plus offset
   initial begin
      for (int k = 0; k < 65536; k++) begin
         mem[k] = 8'h00;
      end
      for (int k = 0; k < 14; k++) begin
         mem[16'h3FF2 + k] = 8'hA0 + 8'(k);
      end
   end
   // Data stand with the strobe; the inverse shows stale reads
   assign o_mem_rdata = i_mem_re ? mem[i_mem_addr] : ~mem[i_mem_addr];
   always @(posedge i_ref_clk) begin
      if (i_mem_we) begin
         mem[i_mem_addr] <= i_mem_wdata;
      end
   end
endmodule : csq_mem_model
`default_nettype wire

/* sim/csq_core_tb_top.sv */
// Self-checking bench for the CPU register and interrupt sequencer
`timescale 1ns/1ps
`default_nettype none
module csq_core_tb_top;
   import csq_pkg::*;
   logic i_ref_clk = 1'b0;
   logic i_srst = 1'b1;
   logic i_cmd_valid = 1'b0;
   csq_cmd_s i_cmd = '0;
   logic i_irq_pin_n = 1'b1;
   logic [3:0] i_periph_req = 4'h0;
   logic [1:0] i_reg_addr = 2'h0;
   logic [7:0] i_reg_wdata = 8'h00;
   logic i_reg_wr = 1'b0;
   logic i_reg_rd = 1'b0;
   logic o_busy, o_mem_we, o_mem_re;
   logic [15:0] o_ea, o_pc, o_mem_addr, ret, d;
   logic [7:0] o_mem_wdata, i_mem_rdata, o_reg_rdata, rd, a, b, x;
   logic [8:0] s;
   logic [4:0] hc;
   int bad_count = 0;
   int cmp_count = 0;

   always #12.5 i_ref_clk = ~i_ref_clk;

   csq_core DUT (.i_ref_clk, .i_srst, .i_cmd_valid, .i_cmd, .o_busy, .o_ea,
      .o_pc, .o_mem_addr, .o_mem_wdata, .o_mem_we, .o_mem_re, .i_mem_rdata,
      .i_irq_pin_n, .i_periph_req, .i_reg_addr, .i_reg_wdata, .i_reg_wr,
      .i_reg_rd, .o_reg_rdata);
   csq_mem_model u_mem (.i_ref_clk, .i_mem_addr(o_mem_addr),
      .i_mem_wdata(o_mem_wdata), .i_mem_we(o_mem_we), .i_mem_re(o_mem_re),
      .o_mem_rdata(i_mem_rdata));

   // Target held in a vector pair, mirroring the model's table fill
   function automatic logic [15:0] vpc(input logic [15:0] base);
      logic [7:0] o;
      o = base[7:0] - 8'hF2 + 8'hA0;
      return {o, o + 8'h01};
   endfunction : vpc

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic test_done;
      $display("cmp=%0d bad=%0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : test_done

   // Bounded wait for the sequencer; a hang counts and ends the run
   task automatic idle;
      int n;
      n = 0;
      while (o_busy !== 1'b0) begin
         @(posedge i_ref_clk);
         #1;
         n++;
         if (n > 60) begin
            bad_count++;
            test_done();
         end
      end
   endtask : idle

   task automatic op(input csq_op_e o, input logic [15:0] v);
      @(posedge i_ref_clk);
      i_cmd_valid <= 1'b1;
      i_cmd <= '{o, v};
      @(posedge i_ref_clk);
      i_cmd_valid <= 1'b0;
      #1;
      idle();
   endtask : op

   task automatic rr(input logic [1:0] ad);
      @(posedge i_ref_clk);
      i_reg_rd <= 1'b1;
      i_reg_addr <= ad;
      @(posedge i_ref_clk);
      i_reg_rd <= 1'b0;
      #1;
      rd = o_reg_rdata;
   endtask : rr

   // Compare flag bits {H,I,N,Z,C} under a mask
   task automatic fc(input logic [4:0] m, input logic [4:0] e);
      rr(CSQ_REG_FLAGS);
      chk(16'(rd[4:0] & m), 16'(e & m));
   endtask : fc

   task automatic req(input logic [3:0] r, input logic pin);
      @(posedge i_ref_clk);
      i_periph_req <= r;
      i_irq_pin_n <= pin;
      repeat (4) @(posedge i_ref_clk);
   endtask : req

   initial begin
      void'($urandom(32'hDACA));
      repeat (6) @(posedge i_ref_clk);
      i_srst <= 1'b0;
      #1;
      idle();
      chk(o_pc, vpc(CSQ_VEC_RST));
      fc(5'h08, 5'h08);
      rr(CSQ_REG_ACK);
      chk(16'(rd), 16'h0000);
      // Timer request with its enable off is ignored even when unmasked
      op(CSQ_OP_STPWT, 16'h0000);
      fc(5'h08, 5'h00);
      req(4'h1, 1'b1);
      ret = o_pc;
      op(CSQ_OP_END, 16'h0000);
      chk(o_pc, ret);
      req(4'h0, 1'b1);
      op(CSQ_OP_SEI, 16'h0000);
      // Random operands with half-carry and carry corners first
      for (int k = 0; k < 12; k++) begin
         a = (k == 0) ? 8'h0F : (k == 1) ? 8'hFF : 8'($urandom);
         b = (k < 2) ? 8'h01 : 8'($urandom);
         d = 16'($urandom);
         op(CSQ_OP_LDA, {8'h00, a});
         fc(5'h06, {2'b00, a[7], a == 8'h00, 1'b0});
         op(CSQ_OP_ADD, {8'h00, b});
         s = {1'b0, a} + {1'b0, b};
         hc = {1'b0, a[3:0]} + {1'b0, b[3:0]};
         fc(5'h17, {hc[4], 1'b0, s[7], s[7:0] == 8'h00, s[8]});
         op(CSQ_OP_INC, 16'h0000);
         s[7:0] = s[7:0] + 8'h01;
         fc(5'h07, {2'b00, s[7], s[7:0] == 8'h00, s[8]});
         op(CSQ_OP_LSL, 16'h0000);
         fc(5'h01, {4'h0, s[7]});
         op(CSQ_OP_BTST, d);
         fc(5'h01, {4'h0, d[0]});
         x = 8'($urandom);
         op(CSQ_OP_LDX, {8'h00, x});
         op(CSQ_OP_IDX0, 16'h0000);
         chk(o_ea, {8'h00, x});
         op(CSQ_OP_IDX8, d);
         chk(o_ea, {8'h00, x} + {8'h00, d[7:0]});
         op(CSQ_OP_IDX16, d);
         chk(o_ea, {8'h00, x} + d);
      end
      op(CSQ_OP_LDA, 16'h0000);
      op(CSQ_OP_SUB, 16'h0001);
      fc(5'h07, 5'b00101);
      op(CSQ_OP_DEC, 16'h0000);
      fc(5'h07, 5'b00101);
      op(CSQ_OP_AND, 16'h0000);
      fc(5'h06, 5'b00010);
      op(CSQ_OP_LDA, 16'h0008);
      op(CSQ_OP_ADC, 16'h0008);
      fc(5'h17, 5'b10000);
      // Program counter stepping, call and return, stack wrap
      ret = o_pc;
      op(CSQ_OP_FETCH, 16'h0000);
      chk(o_pc, ret + 16'h1);
      op(CSQ_OP_JUMP, 16'h0400);
      chk(o_pc, 16'h0400);
      op(CSQ_OP_RSP, 16'h0000);
      op(CSQ_OP_JSR, 16'h1234);
      chk(o_pc, 16'h1234);
      op(CSQ_OP_RTS, 16'h0000);
      chk({u_mem.mem[16'h00FE], u_mem.mem[16'h00FF]}, 16'h0400);
      chk(o_pc, 16'h0400);
      for (int k = 0; k < 33; k++) begin
         op(CSQ_OP_JSR, 16'h2000 + 16'(k));
      end
      op(CSQ_OP_RSP, 16'h0000);
      chk({u_mem.mem[16'h00FE], u_mem.mem[16'h00FF]}, 16'h201F);
      // Masked requests stay latched; external outranks the timer
      rr(CSQ_REG_EN);
      chk(16'(rd), 16'(CSQ_EN_RST));
      op(CSQ_OP_SEI, 16'h0000);
      @(posedge i_ref_clk);
      i_reg_wr <= 1'b1;
      i_reg_addr <= CSQ_REG_EN;
      i_reg_wdata <= 8'h1F;
      @(posedge i_ref_clk);
      i_reg_wr <= 1'b0;
      op(CSQ_OP_LDA, 16'h0055);
      op(CSQ_OP_LDX, 16'h00AA);
      req(4'h1, 1'b0);
      ret = o_pc;
      op(CSQ_OP_END, 16'h0000);
      chk(o_pc, ret);
      rr(CSQ_REG_PEND);
      chk(16'(rd[4:0]), 16'h0003);
      op(CSQ_OP_CLI, 16'h0000);
      op(CSQ_OP_END, 16'h0000);
      chk(o_pc, vpc(CSQ_VEC_EXT));
      fc(5'h08, 5'h08);
      chk({u_mem.mem[16'h00FE], u_mem.mem[16'h00FF]}, ret);
      chk({u_mem.mem[16'h00FD], u_mem.mem[16'h00FC]}, 16'hAA55);
      chk(16'(u_mem.mem[16'h00FB][3]), 16'h0000);
      req(4'h1, 1'b1);
      op(CSQ_OP_RTI, 16'h0000);
      chk(o_pc, ret);
      fc(5'h08, 5'h00);
      // Each peripheral source reaches its own vector
      for (int k = 0; k < 4; k++) begin
         req(4'h1 << k, 1'b1);
         op(CSQ_OP_RSP, 16'h0000);
         op(CSQ_OP_CLI, 16'h0000);
         op(CSQ_OP_END, 16'h0000);
         chk(o_pc, vpc(CSQ_VEC_T16 - 16'(2 * k)));
      end
      req(4'h0, 1'b1);
      // Mid-run reset keeps A and X; software entry ignores the mask
      op(CSQ_OP_LDA, 16'h003C);
      op(CSQ_OP_LDX, 16'h00C3);
      @(posedge i_ref_clk);
      i_srst <= 1'b1;
      repeat (2) @(posedge i_ref_clk);
      i_srst <= 1'b0;
      #1;
      idle();
      chk(o_pc, vpc(CSQ_VEC_RST));
      op(CSQ_OP_SWI, 16'h0000);
      chk(o_pc, vpc(CSQ_VEC_SWI));
      chk({u_mem.mem[16'h00FD], u_mem.mem[16'h00FC]}, 16'hC33C);
      test_done();
   end
endmodule : csq_core_tb_top
`default_nettype wire
